// ### logic/hpps_pkg.sv
package hpps_pkg;

    // pin levels as seen after the two-flop synchroniser
    typedef struct packed {
        logic strap_i2c;     // protocol strap, high selects i2c
        logic sclk;          // serial clock from the host
        logic sdata;         // shared data pin level
        logic addr1;         // address bit 1 pin level
        logic addr0_cs_n;    // address bit 0 / select pin level
        logic dev_rst_n;     // device reset pin
        logic out_dis;       // global output disable pin
        logic realign_n;     // divider realign pin
        logic pll_locked;    // lock state of the main pll
    } hpps_pins_t;

    // reset image follows the internal pulls; device reset reads as asserted
    localparam hpps_pins_t PINS_RST = '{
        strap_i2c:  1'b1,
        sclk:       1'b1,
        sdata:      1'b1,
        addr1:      1'b0,
        addr0_cs_n: 1'b1,
        dev_rst_n:  1'b0,
        out_dis:    1'b0,
        realign_n:  1'b1,
        pll_locked: 1'b0
    };

    typedef enum logic [1:0] {
        ST_HOLD  = 2'b00,
        ST_STRAP = 2'b01,
        ST_RUN   = 2'b11
    } hpps_phase_t;

    typedef enum logic [1:0] {
        MODE_SPI3 = 2'b00,
        MODE_SPI4 = 2'b01,
        MODE_I2C  = 2'b10
    } hpps_mode_t;

    typedef struct packed {
        logic       data_o;       // data pin output value
        logic       data_oe;      // data pin driven
        logic       addr1_o;      // address-1 pin output value
        logic       addr1_oe;     // address-1 pin driven
        logic       core_sclk;    // serial clock to the protocol engine
        logic       core_rx;      // serial data to the protocol engine
        logic       core_sel_n;   // spi select to the protocol engine
        logic [1:0] addr_lsb;     // i2c target address bits 1:0
        logic       regs_default; // holds the register file at defaults
        logic       irq_n;        // status change interrupt, low active
        logic       lock;         // lock indicator
        logic       clk_en;       // clock outputs allowed to run
        logic       div_rst;      // output divider reset
    } hpps_out_t;

    localparam hpps_out_t OUT_RST = '{
        data_o:       1'b0,
        data_oe:      1'b0,
        addr1_o:      1'b0,
        addr1_oe:     1'b0,
        core_sclk:    1'b1,
        core_rx:      1'b1,
        core_sel_n:   1'b1,
        addr_lsb:     2'h0,
        regs_default: 1'b1,
        irq_n:        1'b1,
        lock:         1'b0,
        clk_en:       1'b0,
        div_rst:      1'b1
    };

    typedef struct packed {
        hpps_phase_t phase;
        hpps_mode_t  mode;
        logic        irq_pend;
        hpps_out_t   out;
    } hpps_state_t;

    localparam hpps_state_t STATE_RST = '{
        phase:    ST_HOLD,
        mode:     MODE_I2C,
        irq_pend: 1'b0,
        out:      OUT_RST
    };

endpackage

// ### logic/hpps_sync.sv
`timescale 1ns/1ps
module hpps_sync
(
    input  wire logic                clk,    // system clock
    input  wire logic                rst_n,  // async reset, low active
    input  wire hpps_pkg::hpps_pins_t pins,   // raw pin levels
    output hpps_pkg::hpps_pins_t     synced  // levels after two flops
);
    import hpps_pkg::*;

    typedef struct packed {
        hpps_pins_t meta;
        hpps_pins_t stable;
    } hpps_sync_t;

    hpps_sync_t st_reg;
    hpps_sync_t st_next;

    // first stage feeds the second stage only
    always_comb
    begin
        st_next.meta   = pins;
        st_next.stable = st_reg.meta;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '{meta: PINS_RST, stable: PINS_RST};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign synced = st_reg.stable;

endmodule // hpps_sync

// ### logic/hpps_top.sv
// Overview of operation
// RULE_01: strap high runs the serial port as i2c, strap low as spi.
// RULE_02: data pin is two-way in i2c and 3-wire spi, input-only in 4-wire spi.
// RULE_03: address-1 pin is an undriven input in i2c, driven data output in 4-wire spi.
// RULE_04: address-0 pin is an address input in i2c, low-active select in spi.
// RULE_05: host always supplies the serial clock; the device never drives it.
// RULE_06: interrupt output goes low when any device status change occurs; the code drops status_event while device reset is low.
// RULE_07: device reset input low returns all logic and registers to defaults; the code keeps the lock indicator following the pll.
// RULE_08: clock outputs stay disabled while device reset is in effect.
// RULE_09: output disable high stops all clock outputs; low lets them run.
// RULE_10: lock indicator is driven high while locked, low while out of lock.
// RULE_11: realign input low resets the output dividers to realign clocks.
// RULE_12: in i2c the two address pins form target address bits 1:0.
`timescale 1ns/1ps
module hpps_top
    import hpps_pkg::*;
(
    input  wire logic       clk,                   // 50 MHz system clock
    input  wire logic       rst_n,                 // power-on reset, async, low active
    input  wire logic       protocol_strap,        // pin: high i2c, low spi
    input  wire logic       spi_4wire_cfg,         // config bit: 4-wire spi when set
    input  wire logic       sclk_pin,              // pin: serial clock from host
    input  wire logic       data_pin_in,           // pin: shared data level
    output logic            data_pin_out,          // pin: shared data drive value
    output logic            data_pin_oe,           // pin: shared data driven
    input  wire logic       addr_bit1_or_data_out_in, // pin: address-1 level
    output logic            addr_bit1_or_data_out,    // pin: address-1 drive value
    output logic            addr_bit1_or_data_out_oe, // pin: address-1 driven
    input  wire logic       addr_bit0_or_select_n, // pin: address-0 / select
    input  wire logic       device_reset_n,        // pin: device reset, low active
    input  wire logic       global_output_disable, // pin: high stops clock outputs
    input  wire logic       divider_realign_n,     // pin: low resets output dividers
    input  wire logic       pll_locked,            // pll lock detector level
    input  wire logic       status_event,          // one-cycle status change pulse
    input  wire logic       status_ack,            // one-cycle host status read
    input  wire logic       core_tx_data,          // engine: data to send
    input  wire logic       core_tx_en,            // engine: data phase active
    output logic            core_sclk,             // engine: serial clock
    output logic            serial_data_in,        // engine: received data
    output logic            core_select_n,         // engine: spi select, low active
    output logic            core_i2c_mode,         // engine: i2c protocol active
    output logic            core_spi_4wire,        // engine: 4-wire spi active
    output logic [1:0]      core_addr_lsb,         // engine: i2c address bits 1:0
    output logic            core_regs_default,     // register file held at defaults
    output logic            status_change_irq_n,   // pin: status interrupt, low active
    output logic            pll_lock_indicator,    // pin: high while locked
    output logic            clk_out_enable,        // clock outputs allowed to run
    output logic            divider_reset          // output divider reset
);
    import hpps_pkg::*;

    hpps_pins_t  pins_raw;
    hpps_pins_t  s;
    hpps_state_t r_reg;
    hpps_state_t r_next;

    always_comb
    begin
        pins_raw.strap_i2c  = protocol_strap;
        pins_raw.sclk       = sclk_pin;
        pins_raw.sdata      = data_pin_in;
        pins_raw.addr1      = addr_bit1_or_data_out_in;
        pins_raw.addr0_cs_n = addr_bit0_or_select_n;
        pins_raw.dev_rst_n  = device_reset_n;
        pins_raw.out_dis    = global_output_disable;
        pins_raw.realign_n  = divider_realign_n;
        pins_raw.pll_locked = pll_locked;
    end

    hpps_sync hpps_sync_i
    (
        .clk    (clk),
        .rst_n  (rst_n),
        .pins   (pins_raw),
        .synced (s)
    );

    always_comb
    begin
        r_next = r_reg;
        case (r_reg.phase)
            ST_HOLD:
            begin
                r_next.phase = ST_STRAP;
            end
            ST_STRAP:
            begin
                // strap caught once, after the reset release
                if (s.strap_i2c)                                    // RULE_01
                begin
                    r_next.mode = MODE_I2C;
                end
                else
                begin
                    r_next.mode = spi_4wire_cfg ? MODE_SPI4 : MODE_SPI3;
                end
                r_next.phase = ST_RUN;
            end
            ST_RUN:
            begin
                // wire count may be reconfigured while running spi
                if (r_reg.mode != MODE_I2C)
                begin
                    r_next.mode = spi_4wire_cfg ? MODE_SPI4 : MODE_SPI3;
                end
            end
            default:
            begin
                r_next.phase = ST_HOLD;
            end
        endcase

        // set wins over a same-cycle acknowledge
        r_next.irq_pend = (r_reg.irq_pend & ~status_ack) | status_event;   // RULE_06

        r_next.out              = OUT_RST;
        r_next.out.irq_n        = ~r_next.irq_pend;                         // RULE_06
        r_next.out.lock         = s.pll_locked;                             // RULE_10
        r_next.out.core_sclk    = s.sclk;                                   // RULE_05
        r_next.out.core_rx      = s.sdata;

        if (r_next.phase == ST_RUN)
        begin
            r_next.out.regs_default = 1'b0;
            r_next.out.clk_en       = ~s.out_dis;                           // RULE_09
            r_next.out.div_rst      = ~s.realign_n;                         // RULE_11
            case (r_next.mode)
                MODE_I2C:
                begin
                    // open drain: only ever pulls low
                    r_next.out.data_o   = 1'b0;                             // RULE_02
                    r_next.out.data_oe  = core_tx_en & ~core_tx_data;       // RULE_02
                    r_next.out.addr1_oe = 1'b0;                             // RULE_03
                    r_next.out.addr_lsb = {s.addr1, s.addr0_cs_n};          // RULE_12
                    r_next.out.core_sel_n = 1'b1;                           // RULE_04
                end
                MODE_SPI4:
                begin
                    r_next.out.data_oe    = 1'b0;                           // RULE_02
                    r_next.out.addr1_o    = core_tx_data;                   // RULE_03
                    r_next.out.addr1_oe   = 1'b1;                           // RULE_03
                    r_next.out.core_sel_n = s.addr0_cs_n;                   // RULE_04
                end
                default:
                begin
                    // 3-wire: data pin turns around on the engine's data phase
                    r_next.out.data_o     = core_tx_data;                   // RULE_02
                    r_next.out.data_oe    = core_tx_en & ~s.addr0_cs_n;     // RULE_02
                    r_next.out.core_sel_n = s.addr0_cs_n;                   // RULE_04
                end
            endcase
        end

        // device reset overrides everything but the lock indicator, other outputs go to their reset values
        if (!s.dev_rst_n)                                                   // RULE_08
        begin
            r_next          = STATE_RST;                                    // RULE_07
            r_next.out.lock = s.pll_locked;                                 // RULE_10
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r_reg <= STATE_RST;                                             // RULE_08
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    assign data_pin_out             = r_reg.out.data_o;
    assign data_pin_oe              = r_reg.out.data_oe;
    assign addr_bit1_or_data_out    = r_reg.out.addr1_o;
    assign addr_bit1_or_data_out_oe = r_reg.out.addr1_oe;
    assign core_sclk                = r_reg.out.core_sclk;
    assign serial_data_in           = r_reg.out.core_rx;
    assign core_select_n            = r_reg.out.core_sel_n;
    // mode encoding keeps each flag in a bit of its own, so these leave a flop undecoded
    assign core_i2c_mode            = r_reg.mode[1];
    assign core_spi_4wire           = r_reg.mode[0];
    assign core_addr_lsb            = r_reg.out.addr_lsb;
    assign core_regs_default        = r_reg.out.regs_default;
    assign status_change_irq_n      = r_reg.out.irq_n;
    assign pll_lock_indicator       = r_reg.out.lock;
    assign clk_out_enable           = r_reg.out.clk_en;
    assign divider_reset            = r_reg.out.div_rst;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic run_ok;
    assign run_ok = (r_reg.phase == ST_RUN) && s.dev_rst_n;

    property p_strap_mode;
        $rose(r_reg.phase == ST_RUN) |-> ((r_reg.mode == MODE_I2C) == $past(s.strap_i2c));
    endproperty
    a_strap_mode: assert property (p_strap_mode) // RULE_01
        else $error("mode does not follow strap");

    property p_i2c_data;
        run_ok && r_reg.mode == MODE_I2C |=>
            !data_pin_out && data_pin_oe == $past(core_tx_en & ~core_tx_data);
    endproperty
    a_i2c_data: assert property (p_i2c_data) // RULE_02
        else $error("i2c data pin not open drain");

    property p_spi4_pins;
        run_ok && r_reg.mode == MODE_SPI4 && spi_4wire_cfg |=>
            !data_pin_oe && addr_bit1_or_data_out_oe
            && addr_bit1_or_data_out == $past(core_tx_data);
    endproperty
    a_spi4_pins: assert property (p_spi4_pins) // RULE_03
        else $error("4-wire pin roles wrong");

    property p_i2c_addr1_input;
        run_ok && r_reg.mode == MODE_I2C |=> !addr_bit1_or_data_out_oe;
    endproperty
    a_i2c_addr1_input: assert property (p_i2c_addr1_input) // RULE_03
        else $error("address-1 pin driven in i2c");

    property p_select;
        run_ok && r_reg.mode != MODE_I2C |=> core_select_n == $past(s.addr0_cs_n);
    endproperty
    a_select: assert property (p_select) // RULE_04
        else $error("spi select not passed");

    property p_irq;
        run_ok && status_event |=> !status_change_irq_n;
    endproperty
    a_irq: assert property (p_irq) // RULE_06
        else $error("status change did not assert interrupt");

    property p_dev_reset;
        !s.dev_rst_n |=> core_regs_default && !clk_out_enable
            && status_change_irq_n && r_reg.phase == ST_HOLD;
    endproperty
    a_dev_reset: assert property (p_dev_reset) // RULE_07
        else $error("device reset not applied");

    property p_reset_outputs_off;
        !s.dev_rst_n [*2] |-> !clk_out_enable;
    endproperty
    a_reset_outputs_off: assert property (p_reset_outputs_off) // RULE_08
        else $error("clock outputs enabled in reset");

    property p_out_disable;
        s.out_dis |=> !clk_out_enable;
    endproperty
    a_out_disable: assert property (p_out_disable) // RULE_09
        else $error("outputs not disabled");

    property p_lock;
        1'b1 |=> pll_lock_indicator == $past(s.pll_locked);
    endproperty
    a_lock: assert property (p_lock) // RULE_10
        else $error("lock indicator wrong");

    property p_realign;
        !s.realign_n |=> divider_reset;
    endproperty
    a_realign: assert property (p_realign) // RULE_11
        else $error("divider not reset on realign");

    property p_addr_lsb;
        run_ok && r_reg.mode == MODE_I2C |=>
            core_addr_lsb == $past({s.addr1, s.addr0_cs_n});
    endproperty
    a_addr_lsb: assert property (p_addr_lsb) // RULE_12
        else $error("i2c address bits wrong");

    property p_cov_i2c;
        r_reg.phase == ST_RUN && r_reg.mode == MODE_I2C && data_pin_oe;
    endproperty
    c_cov_i2c: cover property (p_cov_i2c);

    property p_cov_spi4;
        r_reg.phase == ST_RUN && r_reg.mode == MODE_SPI4 && !core_select_n;
    endproperty
    c_cov_spi4: cover property (p_cov_spi4);

    property p_cov_irq_ack;
        !status_change_irq_n ##1 status_ack ##1 status_change_irq_n;
    endproperty
    c_cov_irq_ack: cover property (p_cov_irq_ack);

endmodule // hpps_top

// ### test/hpps_host_model.sv
`timescale 1ns/1ps
module hpps_host_model
(
    input  wire logic clk,        // system clock
    input  wire logic rst_n,      // reset, low active
    input  wire logic i2c_bus,    // i2c wiring, pull-up on the data wire
    input  wire logic frame,      // host runs the serial clock
    input  wire logic host_oe,    // host drives the data wire
    input  wire logic host_val,   // host data value
    input  wire logic dev_oe,     // device drives the data wire
    input  wire logic dev_val,    // device data value
    input  wire logic a1_dev_oe,  // device drives the address-1 wire
    input  wire logic a1_dev_val, // device address-1 value
    input  wire logic a1_board,   // board level strapped on address-1
    output logic      sclk,       // serial clock wire
    output logic      data_lvl,   // resolved data wire
    output logic      a1_lvl      // resolved address-1 wire
);
    logic last_data;

    // clock stands still high between frames
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            sclk <= 1'b1;
        else if (frame)
            sclk <= ~sclk;
        else
            sclk <= 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            last_data <= 1'b0;
        else
            last_data <= data_lvl;
    end

    // no pull in spi: a released wire must not keep its last value
    always_comb
    begin
        if (dev_oe)
            data_lvl = dev_val;
        else if (host_oe)
            data_lvl = host_val;
        else if (i2c_bus)
            data_lvl = 1'b1;
        else
            data_lvl = ~last_data;
        a1_lvl = a1_dev_oe ? a1_dev_val : a1_board;
    end
endmodule // hpps_host_model

// ### test/hpps_top_test.sv
`timescale 1ns/1ps
module hpps_top_test;
    import hpps_pkg::*;
    logic       clk, rst_n, strap, cfg4, frame, host_oe, host_val, a1_board, sel_n;
    logic       dev_rst_n, out_dis, realign_n, pll, ev, ack, tx_d, tx_en;
    logic       sclk, data_lvl, a1_lvl, d_out, d_oe, a1_out, a1_oe, c_sclk, c_rx, c_sel_n;
    logic       c_i2c, c_spi4, c_def, irq_n, lock, clk_en, div_rst;
    logic [1:0] c_addr;
    int         errors;
    int         checks;

    hpps_top hpps_top_i (.clk(clk), .rst_n(rst_n), .protocol_strap(strap),
        .spi_4wire_cfg(cfg4), .sclk_pin(sclk), .data_pin_in(data_lvl), .data_pin_out(d_out),
        .data_pin_oe(d_oe), .addr_bit1_or_data_out_in(a1_lvl), .addr_bit1_or_data_out(a1_out),
        .addr_bit1_or_data_out_oe(a1_oe), .addr_bit0_or_select_n(sel_n),
        .device_reset_n(dev_rst_n), .global_output_disable(out_dis),
        .divider_realign_n(realign_n), .pll_locked(pll), .status_event(ev), .status_ack(ack),
        .core_tx_data(tx_d), .core_tx_en(tx_en), .core_sclk(c_sclk), .serial_data_in(c_rx),
        .core_select_n(c_sel_n), .core_i2c_mode(c_i2c), .core_spi_4wire(c_spi4),
        .core_addr_lsb(c_addr), .core_regs_default(c_def), .status_change_irq_n(irq_n),
        .pll_lock_indicator(lock), .clk_out_enable(clk_en), .divider_reset(div_rst));

    hpps_host_model hpps_host_model_i (.clk(clk), .rst_n(rst_n), .i2c_bus(strap),
        .frame(frame), .host_oe(host_oe), .host_val(host_val), .dev_oe(d_oe), .dev_val(d_out),
        .a1_dev_oe(a1_oe), .a1_dev_val(a1_out), .a1_board(a1_board), .sclk(sclk),
        .data_lvl(data_lvl), .a1_lvl(a1_lvl));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic chk1(input logic act, input logic exp, input string msg);
        checks++;
        if (act !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    task automatic chk2(input logic [1:0] act, input logic [1:0] exp, input string msg);
        checks++;
        if (act !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask

    task automatic give_verdict();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // strap is only caught on the way out of a device reset or the power-on reset
    task automatic restart(input logic s, input logic c);
        dev_rst_n = 1'b0;
        tick(4);
        strap = s;
        cfg4 = c;
        dev_rst_n = 1'b1;
        tick(8);
    endtask

    task automatic t_reset();
        out_dis = 1'b0;
        dev_rst_n = 1'b0;
        tick(5);
        chk1(clk_en, 1'b0, "outputs run in reset");
        chk1(c_def, 1'b1, "regs not at default");
        chk1(div_rst, 1'b1, "dividers free in reset");
        chk1(d_oe, 1'b0, "data driven in reset");
        chk1(lock, 1'b1, "lock lost in reset");
        ev = 1'b1;
        tick(1);
        ev = 1'b0;
        chk1(irq_n, 1'b1, "irq set in reset");
        $display("test reset done");
    endtask

    task automatic t_i2c();
        logic prev;
        restart(1'b1, 1'b0);
        chk1(c_i2c, 1'b1, "not i2c");
        chk1(c_def, 1'b0, "regs held");
        for (int k = 0; k < 4; k++)
        begin
            a1_board = k[1];
            sel_n = k[0];
            tick(4);
            chk2(c_addr, k[1:0], "i2c address");
            chk1(a1_oe, 1'b0, "address-1 driven in i2c");
            chk1(c_sel_n, 1'b1, "select active in i2c");
        end
        tx_en = 1'b1;
        tx_d = 1'b0;
        tick(1);
        chk1(d_oe, 1'b1, "i2c low not driven");
        chk1(d_out, 1'b0, "i2c drive value");
        tx_d = 1'b1;
        tick(1);
        chk1(d_oe, 1'b0, "i2c high driven");
        tx_en = 1'b0;
        host_oe = 1'b1;
        host_val = 1'b0;
        tick(4);
        chk1(c_rx, 1'b0, "i2c data in");
        // board pull-up follows the strap in the model, so release before the strap flips
        host_oe = 1'b0;
        tick(4);
        chk1(c_rx, 1'b1, "i2c released data");
        strap = 1'b0;
        tick(4);
        chk1(c_i2c, 1'b1, "strap taken in run");
        strap = 1'b1;
        frame = 1'b1;
        tick(5);
        prev = c_sclk;
        tick(1);
        chk1(c_sclk, ~prev, "serial clock frozen");
        frame = 1'b0;
        tick(5);
        chk1(c_sclk, 1'b1, "serial clock idle");
        $display("test i2c done");
    endtask

    task automatic t_spi4();
        restart(1'b0, 1'b1);
        chk1(c_i2c, 1'b0, "not spi");
        chk1(c_spi4, 1'b1, "not 4-wire");
        chk1(a1_oe, 1'b1, "data out not driven");
        tx_d = 1'b1;
        tick(1);
        chk1(a1_out, 1'b1, "data out high");
        tx_d = 1'b0;
        tick(1);
        chk1(a1_out, 1'b0, "data out low");
        tx_en = 1'b1;
        sel_n = 1'b0;
        host_oe = 1'b1;
        host_val = 1'b1;
        tick(4);
        chk1(d_oe, 1'b0, "4-wire data in driven");
        chk1(c_sel_n, 1'b0, "select not seen");
        chk2(c_addr, 2'h0, "address in spi");
        chk1(c_rx, 1'b1, "spi data in high");
        host_val = 1'b0;
        tick(4);
        chk1(c_rx, 1'b0, "spi data in low");
        host_oe = 1'b0;
        tx_en = 1'b0;
        sel_n = 1'b1;
        tick(4);
        chk1(c_sel_n, 1'b1, "select stuck");
        $display("test spi4 done");
    endtask

    task automatic t_spi3();
        cfg4 = 1'b0;
        tick(4);
        chk1(c_spi4, 1'b0, "not 3-wire");
        chk1(a1_oe, 1'b0, "address-1 driven in 3-wire");
        tx_en = 1'b1;
        tx_d = 1'b1;
        sel_n = 1'b0;
        tick(4);
        chk1(d_oe, 1'b0 ^ 1'b1, "3-wire data not driven");
        chk1(d_out, 1'b1, "3-wire drive value");
        sel_n = 1'b1;
        tick(4);
        chk1(d_oe, 1'b0, "driven while unselected");
        tx_en = 1'b0;
        $display("test spi3 done");
    endtask

    task automatic t_irq();
        ev = 1'b1;
        tick(1);
        ev = 1'b0;
        chk1(irq_n, 1'b0, "irq not raised");
        tick(2);
        chk1(irq_n, 1'b0, "irq dropped");
        ev = 1'b1;
        ack = 1'b1;
        tick(1);
        ev = 1'b0;
        ack = 1'b0;
        chk1(irq_n, 1'b0, "ack beat event");
        tick(1);
        chk1(irq_n, 1'b0, "irq lost");
        ack = 1'b1;
        tick(1);
        ack = 1'b0;
        chk1(irq_n, 1'b1, "irq not cleared");
        $display("test irq done");
    endtask

    task automatic t_outs();
        out_dis = 1'b1;
        tick(2);
        chk1(clk_en, 1'b1, "disable too early");
        tick(1);
        chk1(clk_en, 1'b0, "outputs not disabled");
        out_dis = 1'b0;
        tick(4);
        chk1(clk_en, 1'b1, "outputs not enabled");
        realign_n = 1'b0;
        tick(4);
        chk1(div_rst, 1'b1, "dividers not reset");
        realign_n = 1'b1;
        tick(4);
        chk1(div_rst, 1'b0, "dividers held");
        pll = 1'b0;
        tick(4);
        chk1(lock, 1'b0, "lock high unlocked");
        pll = 1'b1;
        tick(4);
        chk1(lock, 1'b1, "lock low locked");
        $display("test outputs done");
    endtask

    initial
    begin
        {strap, cfg4, frame, host_oe, host_val, a1_board} = 6'h20;
        {sel_n, dev_rst_n, out_dis, realign_n, pll, ev, ack, tx_d, tx_en} = 9'h1b0;
        errors = 0;
        checks = 0;
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(2);
        t_reset();
        t_i2c();
        t_spi4();
        t_spi3();
        t_irq();
        t_outs();
        give_verdict();
    end

    // whole run needs about 130 cycles
    initial
    begin
        #(3000 * 20);
        errors++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        give_verdict();
    end
endmodule // hpps_top_test
